// ===== pkg/area_select_pkg.sv
/*
  Constants for the chip-area select decoder: register map, reset values,
  bank geometry and field positions.
  Assumes a 12-bit APB byte address space with 32-bit data.
*/
package area_select_pkg;
  localparam int unsigned num_signals = 8;
  localparam int unsigned addr_w = 28;
  localparam int unsigned paddr_w = 12;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [31:0] ctrl_0_index = 32'hFFFFF060;
  localparam logic [31:0] ctrl_1_index = 32'hFFFFF062;
  localparam logic [11:0] ctrl_0_addr = {ctrl_0_index[9:0], 2'b00};
  localparam logic [11:0] ctrl_1_addr = {ctrl_1_index[9:0], 2'b00};
  localparam logic [11:0] mode_addr = 12'h190;
  localparam logic [11:0] attr_addr = 12'h194;
  localparam logic [11:0] status_addr = 12'h198;
  localparam logic [15:0] ctrl_0_reset = 16'h2C11;
  localparam logic [15:0] ctrl_1_reset = 16'h2C11;
  localparam logic [31:0] attr_reset = 32'h0000_0000;
  localparam logic mode_reset = 1'b0;
  // attribute nibble per area: [1:0] width, [2] big endian, [3] cacheable
  localparam int unsigned attr_bits = 4;
  localparam int unsigned width_lsb = 0;
  localparam int unsigned endian_bit = 2;
  localparam int unsigned cache_bit = 3;
  // 64 MB mode: each 32 MB half holds banks of 2,2,2,2,4,4,8,8 MB
  localparam int unsigned half_msb = 25;
  localparam int unsigned area_lsb = 26;
  localparam int unsigned mb2_lsb = 21;
  localparam int unsigned mb4_lsb = 22;
  localparam int unsigned mb8_lsb = 23;
  localparam int unsigned quarter_lsb = 24;
  localparam logic [3:0] strb_all = 4'hF;
endpackage

// ===== verilog/area_claim_resolver.sv
/*
  Combinational bank decode and overlap resolution for the eight select
  signals. Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module area_claim_resolver
  import area_select_pkg::*;
(
  input wire logic [addr_w-1:0] addr,
  input wire logic mode_256,
  input wire logic [15:0] ctrl_0,
  input wire logic [15:0] ctrl_1,
  output logic [num_signals-1:0] select
);
  logic [2:0] bank;
  logic [1:0] area;
  logic [1:0] slice;
  logic [num_signals-1:0] claim;
  logic [3:0] en;

  // one nibble of enables against the bank, 64 MB layout
  function automatic logic nib_64(input logic [3:0] en, input logic [1:0] kind,
                                  input logic [2:0] b);
    logic hit;
    hit = 1'b0;
    case (kind)
      2'd0: hit = b[2] ? 1'b0 : en[b[1:0]];
      2'd1: hit = b[2] ? ((b[1:0] == 2'd0) ? en[2] : (b[1:0] == 2'd1) ? en[3] : 1'b0)
                       : en[{1'b0, b[1]}];
      2'd2: hit = b[2] ? 1'b0 : en[b[1:0]];
      default: hit = b[2] ? ((b[1:0] < 2'd2) ? en[1] : en[{1'b1, b[0]}]) : en[0];
    endcase
    return hit;
  endfunction

  // priority within a group of four claims, order given as indices
  function automatic logic [3:0] pick(input logic [3:0] c, input logic [1:0] p0,
                                      input logic [1:0] p1, input logic [1:0] p2,
                                      input logic [1:0] p3);
    logic [3:0] w;
    w = 4'h0;
    if (c[p0]) w[p0] = 1'b1;
    else if (c[p1]) w[p1] = 1'b1;
    else if (c[p2]) w[p2] = 1'b1;
    else if (c[p3]) w[p3] = 1'b1;
    return w;
  endfunction

  always_comb begin
    en = 4'h0;
    area = addr[area_lsb+1:area_lsb];
    slice = addr[quarter_lsb:mb8_lsb];
    // bank within a 32 MB half
    if (addr[quarter_lsb]) bank = {2'b11, addr[mb8_lsb]};
    else if (addr[mb8_lsb]) bank = {2'b10, addr[mb4_lsb]};
    else bank = {1'b0, addr[mb4_lsb:mb2_lsb]};
    claim = '0;
    for (int s = 0; s < num_signals; s++) begin
      // modulo keeps the unused branch's part-select inside the register
      en = (s < 4) ? ctrl_0[4*(s%4) +: 4] : ctrl_1[4*((7-s)%4) +: 4];
      if (mode_256) begin
        // area n/2, one enable per 8 MB slice, repeating in each 32 MB half
        claim[s] = (area == 2'(s / 2)) && en[slice];
      end else begin
        // lower group covers the low half, upper group the high half
        claim[s] = (addr[half_msb] == (s >= 4)) && (area == 2'd0)
                   && nib_64(en, 2'(s % 4), bank);
      end
    end
    // overlap resolution per group
    select[3:0] = pick(claim[3:0], 2'd0, 2'd2, 2'd1, 2'd3);
    select[7:4] = pick(claim[7:4], 2'd3, 2'd1, 2'd2, 2'd0);
  end
endmodule
`default_nettype wire

// ===== verilog/area_select_decoder.sv
/*
  Chip-area select decoder with APB register file. Latches the select
  signals and per-area attributes at the start of each bus access.
  Assumes an APB4 master and an access source giving start/done pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module area_select_decoder
  import area_select_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [paddr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_start,
  input wire logic acc_done,
  input wire logic [addr_w-1:0] acc_addr,
  output logic [num_signals-1:0] area_select_signal_n,
  output logic [1:0] bus_width,
  output logic big_endian,
  output logic cacheable
);
  logic [15:0] ctrl_0_r, ctrl_0_nxt, ctrl_1_r, ctrl_1_nxt;
  logic [31:0] attr_r, attr_nxt;
  logic mode_r, mode_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [num_signals-1:0] sel_r, sel_nxt;
  logic [1:0] width_r, width_nxt;
  logic endian_r, endian_nxt, cache_r, cache_nxt, busy_r, busy_nxt;
  logic [num_signals-1:0] resolved;
  logic access_phase, mapped, word_ok, wr_fire;
  logic [attr_bits-1:0] at;

  function automatic logic [attr_bits-1:0] attr_of(input logic [31:0] a,
                                                   input logic [num_signals-1:0] s);
    logic [attr_bits-1:0] r;
    r = '0;
    for (int i = 0; i < num_signals; i++) begin
      if (s[i]) r = r | a[attr_bits*i +: attr_bits];
    end
    return r;
  endfunction

  area_claim_resolver u_resolver (
    .addr(acc_addr),
    .mode_256(mode_r),
    .ctrl_0(ctrl_0_r),
    .ctrl_1(ctrl_1_r),
    .select(resolved)
  );

  // register bus: one wait state, answer on the second access cycle
  always_comb begin
    access_phase = psel && penable && !pready_r;
    mapped = (paddr == ctrl_0_addr) || (paddr == ctrl_1_addr) || (paddr == mode_addr)
             || (paddr == attr_addr) || (paddr == status_addr);
    // control registers take writes with both low byte strobes set; mode and attr need all four
    word_ok = !pwrite || (paddr == status_addr) ? 1'b1
              : ((paddr == ctrl_0_addr) || (paddr == ctrl_1_addr)) ? (pstrb[1:0] == 2'b11)
              : (pstrb == strb_all);
    wr_fire = access_phase && pwrite && mapped && word_ok && (paddr != status_addr);
    pready_nxt = access_phase;
    pslverr_nxt = access_phase && (!mapped || !word_ok || (pwrite && paddr == status_addr));
    prdata_nxt = prdata_r;
    if (access_phase && !pwrite) begin
      case (paddr)
        ctrl_0_addr: prdata_nxt = {16'h0000, ctrl_0_r};
        ctrl_1_addr: prdata_nxt = {16'h0000, ctrl_1_r};
        mode_addr: prdata_nxt = {31'h0000_0000, mode_r};
        attr_addr: prdata_nxt = attr_r;
        status_addr: prdata_nxt = {23'h00_0000, busy_r, sel_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_0_nxt = ctrl_0_r;
    ctrl_1_nxt = ctrl_1_r;
    mode_nxt = mode_r;
    attr_nxt = attr_r;
    if (wr_fire) begin
      case (paddr)
        ctrl_0_addr: ctrl_0_nxt = pwdata[15:0];
        ctrl_1_addr: ctrl_1_nxt = pwdata[15:0];
        mode_addr: mode_nxt = pwdata[0];
        attr_addr: attr_nxt = pwdata;
        default: attr_nxt = attr_r;
      endcase
    end
  end

  // select and attributes are latched at access start; select clears at access done, attributes hold
  always_comb begin
    at = attr_of(attr_r, resolved);
    sel_nxt = sel_r;
    width_nxt = width_r;
    endian_nxt = endian_r;
    cache_nxt = cache_r;
    busy_nxt = busy_r;
    if (acc_start) begin
      sel_nxt = resolved;
      width_nxt = at[width_lsb +: 2];
      endian_nxt = at[endian_bit];
      cache_nxt = at[cache_bit];
      busy_nxt = 1'b1;
    end else if (acc_done) begin
      sel_nxt = '0;
      busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_0_r <= ctrl_0_reset;
      ctrl_1_r <= ctrl_1_reset;
      attr_r <= attr_reset;
      mode_r <= mode_reset;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      sel_r <= '0;
      width_r <= 2'h0;
      endian_r <= 1'b0;
      cache_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      ctrl_0_r <= ctrl_0_nxt;
      ctrl_1_r <= ctrl_1_nxt;
      attr_r <= attr_nxt;
      mode_r <= mode_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      sel_r <= sel_nxt;
      width_r <= width_nxt;
      endian_r <= endian_nxt;
      cache_r <= cache_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign area_select_signal_n = sel_r;
  assign bus_width = width_r;
  assign big_endian = endian_r;
  assign cacheable = cache_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    acc_start;
  endsequence
  sequence s_held;
    !acc_start && !acc_done;
  endsequence

  chk_select_onehot_low: assert property ($onehot0(area_select_signal_n[3:0]))
    else $error("lower select group has two winners");
  chk_select_onehot_high: assert property ($onehot0(area_select_signal_n[7:4]))
    else $error("upper select group has two winners");
  chk_zero_wins: assert property (acc_start && u_resolver.claim[0] |=> area_select_signal_n[0]
                                   && !area_select_signal_n[2])
    else $error("signal 0 lost to a lower priority claim");
  chk_seven_wins: assert property (acc_start && u_resolver.claim[7]
                                    |=> area_select_signal_n[7:4] == 4'h8)
    else $error("signal 7 did not win its group");
  chk_resolve_any: assert property (acc_start && u_resolver.claim[2] && u_resolver.claim[1]
                                     && !u_resolver.claim[0] |=> area_select_signal_n[2]
                                     && !area_select_signal_n[1])
    else $error("overlap of signals 2 and 1 not resolved");
  chk_hold_access: assert property (s_start ##1 s_held |=> $stable(area_select_signal_n)
                                     && $stable(bus_width))
    else $error("select changed during an access");
  chk_bank0_enable: assert property (acc_start && !mode_r && acc_addr[27:21] == 7'h00
                                      && ctrl_0_r[0] |=> area_select_signal_n[0])
    else $error("bank 0 enable did not raise signal 0");
  chk_partial_refused: assert property (psel && penable && !pready && pwrite
                                         && paddr == ctrl_0_addr && pstrb[1:0] != 2'b11
                                         |=> pslverr && $stable(ctrl_0_r))
    else $error("partial write reached a control register");
  chk_write_lands: assert property (psel && penable && !pready && pwrite
                                     && paddr == ctrl_1_addr && pstrb == strb_all
                                     |=> ctrl_1_r == $past(pwdata[15:0]))
    else $error("control register 1 write lost");
  chk_attr_follow: assert property (acc_start && resolved[0]
                                     |=> {cacheable, big_endian, bus_width}
                                     == $past(attr_r[attr_bits-1:0]))
    else $error("area attribute not taken from winning area");
endmodule
`default_nettype wire

// ===== dv/access_responder.sv
/*
  Far-side model: ends each bus access a chosen number of cycles after it starts.
  Assumes acc_start pulses from the bench and a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module access_responder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic acc_start,
  input wire logic [3:0] lat,
  output logic acc_done
);
  logic busy_r;
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    acc_done <= 1'b0;
    if (!rst_b) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (acc_start) begin
      busy_r <= 1'b1;
      cnt_r <= lat;
    end else if (busy_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (busy_r) begin
      // access ends here
      acc_done <= 1'b1;
      busy_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
/*
  Self-checking bench for the area select decoder.
  Assumes APB with one wait state and the responder ending accesses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import area_select_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_start = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [27:0] acc_addr = 28'h0;
  logic [3:0] lat = 4'h2;
  logic [31:0] prdata;
  logic pready, pslverr, acc_done, big_endian, cacheable;
  logic [7:0] sel;
  logic [1:0] bus_width;
  int fails = 0, compares = 0, cyc = 0;
  localparam logic [31:0] av = 32'hFEDCBA98;
  // ctrl_0, ctrl_1, mode, access address, expected selects
  logic [71:0] rows [18] = '{
    72'h2C11_2C11_0_0000000_01, 72'h2C11_2C11_0_0200000_02, 72'h2C11_2C11_0_07FFFFF_04,
    72'h2C11_2C11_0_0800000_08, 72'h2C11_2C11_0_0FFFFFF_08, 72'h2C11_2C11_0_1000000_00,
    72'h2C11_2C11_0_2000000_80, 72'h2C11_2C11_0_2800000_20, 72'h4000_2C11_0_1000000_08,
    72'h4000_2C11_0_1800000_00, 72'h1110_1110_0_0000000_04, 72'h1010_1110_0_2000000_20,
    72'h1010_1010_0_0000000_02, 72'h1010_1010_0_2000000_40, 72'h2C11_2C11_1_4800000_08,
    72'h2C11_2C11_1_5800000_04, 72'h2C11_2C11_1_C000000_80, 72'h2C11_2C11_1_0000000_01};
  always #5 clk = ~clk;
  area_select_decoder dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_start(acc_start), .acc_done(acc_done),
    .acc_addr(acc_addr), .area_select_signal_n(sel), .bus_width(bus_width),
    .big_endian(big_endian), .cacheable(cacheable));
  access_responder resp (.clk(clk), .rst_b(rst_b), .acc_start(acc_start), .lat(lat),
    .acc_done(acc_done));
  task automatic end_sim();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      fails++;
      $display("BAD %0t apb answer timeout", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk({31'h0, e}, {31'h0, xe});
    if (!xe) chk(r, x);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, s, r, e);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic acc(input logic [27:0] a, input logic [7:0] es, input logic w);
    int n;
    logic [3:0] ea;
    ea = 4'h0;
    for (int k = 0; k < 8; k++) begin
      if (es[k]) ea = av[4*k+:4];
    end
    @(posedge clk) acc_start <= 1'b1;
    acc_addr <= a;
    @(posedge clk) acc_start <= 1'b0;
    #1;
    chk({24'h0, sel}, {24'h0, es});
    chk({28'h0, cacheable, big_endian, bus_width}, {28'h0, ea});
    if (w) begin
      wr(ctrl_0_addr, 32'h0010, 4'hF, 1'b0);
      #1;
      chk({24'h0, sel}, {24'h0, es});
      rd(status_addr, {23'h0, 1'b1, es}, 1'b0);
    end
    n = 0;
    while (acc_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40) begin
      fails++;
      $display("BAD %0t access end timeout", $time);
    end
    @(posedge clk);
    #1;
    chk({24'h0, sel}, 32'h0);
  endtask
  task automatic t_regs();
    rd(ctrl_0_addr, 32'h2C11, 1'b0);
    rd(ctrl_1_addr, 32'h2C11, 1'b0);
    rd(mode_addr, 32'h0, 1'b0);
    rd(attr_addr, 32'h0, 1'b0);
    rd(12'h1FC, 32'h0, 1'b1);
    wr(ctrl_0_addr, 32'h1234, 4'h1, 1'b1);
    rd(ctrl_0_addr, 32'h2C11, 1'b0);
    wr(status_addr, 32'h1, 4'hF, 1'b1);
  endtask
  task automatic t_map();
    logic [71:0] r;
    wr(attr_addr, av, 4'hF, 1'b0);
    foreach (rows[i]) begin
      r = rows[i];
      wr(ctrl_0_addr, {16'h0, r[71:56]}, 4'hF, 1'b0);
      wr(ctrl_1_addr, {16'h0, r[55:40]}, 4'hF, 1'b0);
      wr(mode_addr, {28'h0, r[39:36]}, 4'hF, 1'b0);
      acc(r[35:8], r[7:0], 1'b0);
    end
  endtask
  task automatic t_live();
    wr(mode_addr, 32'h0, 4'hF, 1'b0);
    lat <= 4'hA;
    acc(28'h0, 8'h01, 1'b1);
    lat <= 4'h1;
    acc(28'h0, 8'h02, 1'b0);
    rd(status_addr, 32'h0, 1'b0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("BAD %0t run timeout", $time);
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_map();
    t_live();
    end_sim();
  end
endmodule
`default_nettype wire
